// >>> verilog/link_monitor_strap_status.sv
module link_monitor_strap_status #(
    parameter int STRAP_SETTLE = lmss_pkg::STRAP_SETTLE_CYCLES
) (
    input wire logic clk_sys_i, // Pixel and link clock
    input wire logic reset_i, // Asynchronous reset, active high
    input wire logic [7:0] reg_addr_i, // Register offset
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    input wire logic [7:0] reg_wdata_i, // Write data
    output logic [7:0] reg_rdata_o, // Read data, registered
    output logic reg_rvalid_o, // Read data valid pulse
    input wire logic [2:0] index_strap_level_i, // Index strap comparator code
    input wire logic [2:0] mode_strap_level_i, // Mode strap comparator code
    input wire logic err_clk0_i, // First embedded clock bit fault
    input wire logic err_clk1_i, // Second embedded clock bit fault
    input wire logic err_parity_i, // Parity fault
    input wire logic err_dc_balance_i, // Dc balance bit fault
    input wire logic filter_wait_i, // Equalizer filter wait period active
    input wire logic relock_i, // Receiver lock acquired pulse
    output logic lock_o, // Receiver locked
    output logic lock_lost_o, // Lock dropped pulse
    output logic [3:0] error_count_o, // Current error count
    output logic encoder_crc_enable_o, // Encoder CRC check active
    input wire logic raw_mode_i, // Receiver in raw mode
    input wire logic frame_valid_i, // Received frame_valid
    output logic frame_start_o // Frame start packet request pulse
);

    // One-hot lock states; with only two, each state is a single flop bit
    typedef enum logic [1:0] {
        LINK_UNLOCKED = 2'b01,
        LINK_LOCKED = 2'b10
    } link_state_t;

    // Saturating increment shared by the error and frame-valid counters
    // Eight bits wide so that one function serves both counter widths
    // Saturation keeps a long frame from wrapping back below the minimum
    // and firing a second frame start in the same frame
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        logic [7:0] r;
        r = (v == 8'hff) ? v : v + 8'h01;
        return r;
    endfunction : sat_inc

    // Strap decode results
    // Both decoders share one settle length; the done bits read as zero
    // until the code has held steady for the whole window

    logic [2:0] index_strap_value;
    logic index_decode_complete;
    logic [2:0] mode_strap_value;
    logic mode_decode_complete;

    // Index strap decoder
    // Each strap is taken only in the settle window after reset; moving
    // a strap later has no effect until the next reset
    strap_decoder #(
        .WIDTH(lmss_pkg::STRAP_W),
        .SETTLE_CYCLES(STRAP_SETTLE)
    ) u_index_dec (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .level_i(index_strap_level_i),
        .value_o(index_strap_value),
        .done_o(index_decode_complete)
    );

    // Mode strap decoder
    // Same settle rule as the index strap; the two finish independently
    strap_decoder #(
        .WIDTH(lmss_pkg::STRAP_W),
        .SETTLE_CYCLES(STRAP_SETTLE)
    ) u_mode_dec (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .level_i(mode_strap_level_i),
        .value_o(mode_strap_value),
        .done_o(mode_decode_complete)
    );

    // Control registers
    // All fields return to their reset defaults whenever reset_i rises

    // Software view of the link error control and encoder control bytes;
    // reserved bits of both read back as constants and hold no state
    logic ignore_errors_filter_wait_q;
    logic err_count_en_q;
    logic [3:0] error_lock_threshold_q;
    logic encoder_crc_disable_q;
    logic [7:0] frame_min_q;

    // Address decode
    // Only the three writable offsets decode a write strobe; the status
    // byte is read-only, so a stray write cannot disturb the strap result
    wire wr_lec = reg_wr_i && (reg_addr_i == lmss_pkg::ADDR_LINK_ERR_CTL);
    wire wr_enc = reg_wr_i && (reg_addr_i == lmss_pkg::ADDR_ENC_CRC_CTL);
    wire wr_frame_min = reg_wr_i && (reg_addr_i == lmss_pkg::ADDR_FRAME_MIN_TIME);

    // Writes to read-only and reserved offsets are dropped silently
    // A new threshold applies from the next edge, so lowering it below the
    // running count drops lock on the next counted error
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            ignore_errors_filter_wait_q <= lmss_pkg::LEC_FILT_WAIT_RST;
            err_count_en_q <= lmss_pkg::LEC_CNT_EN_RST;
            error_lock_threshold_q <= lmss_pkg::LEC_THRESH_RST;
            encoder_crc_disable_q <= lmss_pkg::ENC_CRC_DIS_RST;
            frame_min_q <= lmss_pkg::FRAME_MIN_RST;
        end else begin
            if (wr_lec) begin
                ignore_errors_filter_wait_q <= reg_wdata_i[lmss_pkg::LEC_FILT_WAIT_BIT];
                err_count_en_q <= reg_wdata_i[lmss_pkg::LEC_CNT_EN_BIT];
                error_lock_threshold_q <= reg_wdata_i[lmss_pkg::LEC_THRESH_LSB +: 4];
            end
            if (wr_enc) begin
                encoder_crc_disable_q <= reg_wdata_i[lmss_pkg::ENC_CRC_DIS_BIT];
            end
            if (wr_frame_min) begin
                frame_min_q <= reg_wdata_i;
            end
        end
    end

    // Encoder CRC is active low in the control bit
    // It resets to one, so the check stays off until software enables it
    assign encoder_crc_enable_o = ~encoder_crc_disable_q;

    // Link error counter and lock state
    // While locked, counting only steps the counter to values below the threshold

    link_state_t state_q;
    link_state_t state_d;
    logic [3:0] err_cnt_q;
    logic [3:0] err_cnt_d;
    logic lost_q;
    logic lost_d;

    // Any of the four monitored bits marks the frame as faulty
    // Several faults in one frame still count once, as one bad frame
    wire any_err = err_clk0_i | err_clk1_i | err_parity_i | err_dc_balance_i;
    // Filter wait masking only applies when software asked for it
    // Masking happens before both the counter and the drop decision
    wire err_masked = ignore_errors_filter_wait_q & filter_wait_i;
    wire err_seen = any_err & ~err_masked;
    // Next count compared at five bits so a threshold of 15 still works
    wire [4:0] err_next = {1'b0, err_cnt_q} + 5'h01;
    // A threshold of zero acts as one: the first error already reaches it
    wire thresh_hit = (err_next >= {1'b0, error_lock_threshold_q});
    // Disabled counting means one error is enough
    wire drop_lock = err_seen & (err_count_en_q ? thresh_hit : 1'b1);
    // Stepped count; the threshold drops lock before the nibble can wrap
    wire [7:0] err_inc = sat_inc({4'h0, err_cnt_q});

    // Lock state machine
    // Errors while unlocked are ignored, and so is a relock while locked
    always_comb begin
        state_d = state_q;
        err_cnt_d = err_cnt_q;
        lost_d = 1'b0;
        unique case (state_q)
            LINK_UNLOCKED: begin
                // The counter is held at zero for the whole unlocked time
                err_cnt_d = 4'h0;
                if (relock_i) begin
                    state_d = LINK_LOCKED;
                    err_cnt_d = 4'h0;
                end
            end
            LINK_LOCKED: begin
                // Dropping lock wins over counting in the same cycle
                if (drop_lock) begin
                    state_d = LINK_UNLOCKED;
                    err_cnt_d = 4'h0;
                    lost_d = 1'b1;
                end else if (err_seen && err_count_en_q) begin
                    err_cnt_d = err_inc[3:0];
                end
            end
        endcase
    end

    // Short state update; the counter shares the pixel clock
    // Lock, count and drop pulse move together, so software never sees a
    // dropped lock next to a stale count
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= LINK_UNLOCKED;
            err_cnt_q <= 4'h0;
            lost_q <= 1'b0;
        end else begin
            state_q <= state_d;
            err_cnt_q <= err_cnt_d;
            lost_q <= lost_d;
        end
    end

    // Outputs come straight from the state and counter flops
    // The drop pulse is one cycle wide, on the edge that drops lock
    assign lock_o = (state_q == LINK_LOCKED);
    assign lock_lost_o = lost_q;
    assign error_count_o = err_cnt_q;

    // Frame-valid minimum time
    // The minimum is counted in link clock periods, the clock of this block

    logic [7:0] frame_cnt_q;
    logic frame_sent_q;
    logic fs_q;

    // Counts cycles already spent with frame_valid high in this frame
    // Outside raw mode the counter stays at zero and no start is requested
    wire frame_active = raw_mode_i & frame_valid_i;
    // A minimum of N lets the start go out on the high cycle after N
    wire fs_fire = frame_active & ~frame_sent_q & (frame_cnt_q >= frame_min_q);

    // One frame start per frame_valid pulse; short pulses produce none
    // The sent flag holds off repeats while frame_valid stays high
    // Raising the minimum mid-frame delays the start but never repeats it
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            frame_cnt_q <= 8'h00;
            frame_sent_q <= 1'b0;
            fs_q <= 1'b0;
        end else begin
            frame_cnt_q <= frame_active ? sat_inc(frame_cnt_q) : 8'h00;
            frame_sent_q <= frame_active & (frame_sent_q | fs_fire);
            fs_q <= fs_fire;
        end
    end

    // Registered pulse, one cycle wide
    assign frame_start_o = fs_q;

    // Read path
    // Reads have no side effect, so polling the status byte is safe

    logic [7:0] rd_mux;
    logic [7:0] rdata_q;
    logic rvalid_q;

    // Status byte assembled from the two strap decoders
    wire [7:0] strap_sts = {index_decode_complete, index_strap_value,
                            mode_decode_complete, mode_strap_value};
    // Reserved top bits of the link error control read as zero
    wire [7:0] lec_rd = {2'b00, ignore_errors_filter_wait_q, err_count_en_q,
                         error_lock_threshold_q};
    // Encoder control keeps its reserved low bits at their fixed value
    wire [7:0] enc_rd = {encoder_crc_disable_q, lmss_pkg::ENC_RSVD_VAL};

    // Unmapped offsets read as zero
    // The mux follows the address every cycle; only the read strobe
    // decides when its output is captured
    always_comb begin
        rd_mux = 8'h00;
        unique case (reg_addr_i)
            lmss_pkg::ADDR_RSVD_B6: rd_mux = lmss_pkg::RSVD_B6_VAL;
            lmss_pkg::ADDR_RSVD_B7: rd_mux = lmss_pkg::RSVD_B7_VAL;
            lmss_pkg::ADDR_STRAP_STS: rd_mux = strap_sts;
            lmss_pkg::ADDR_LINK_ERR_CTL: rd_mux = lec_rd;
            lmss_pkg::ADDR_ENC_CRC_CTL: rd_mux = enc_rd;
            lmss_pkg::ADDR_RSVD_BB: rd_mux = lmss_pkg::RSVD_BB_VAL;
            lmss_pkg::ADDR_FRAME_MIN_TIME: rd_mux = frame_min_q;
            lmss_pkg::ADDR_RSVD_BD: rd_mux = lmss_pkg::RSVD_BD_VAL;
            default: rd_mux = 8'h00;
        endcase
    end

    // Registered read data costs a cycle of latency but keeps the mux
    // off the output pins
    // Read data holds until the next read strobe
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end else begin
            if (reg_rd_i) begin
                rdata_q <= rd_mux;
            end
            rvalid_q <= reg_rd_i;
        end
    end

    // Both read outputs come from flops
    assign reg_rdata_o = rdata_q;
    assign reg_rvalid_o = rvalid_q;

endmodule : link_monitor_strap_status

// >>> verilog/lmss_pkg.sv
package lmss_pkg;

    // Register offsets on the device register port
    localparam logic [7:0] ADDR_RSVD_B6 = 8'hb6;
    localparam logic [7:0] ADDR_RSVD_B7 = 8'hb7;
    localparam logic [7:0] ADDR_STRAP_STS = 8'hb8;
    localparam logic [7:0] ADDR_LINK_ERR_CTL = 8'hb9;
    localparam logic [7:0] ADDR_ENC_CRC_CTL = 8'hba;
    localparam logic [7:0] ADDR_RSVD_BB = 8'hbb;
    localparam logic [7:0] ADDR_FRAME_MIN_TIME = 8'hbc;
    localparam logic [7:0] ADDR_RSVD_BD = 8'hbd;

    // Reserved register read values
    localparam logic [7:0] RSVD_B6_VAL = 8'h18;
    localparam logic [7:0] RSVD_B7_VAL = 8'h00;
    localparam logic [7:0] RSVD_BB_VAL = 8'h74;
    localparam logic [7:0] RSVD_BD_VAL = 8'h00;

    // Strap status field layout
    localparam int STS_INDEX_DONE_BIT = 7;
    localparam int STS_INDEX_LSB = 4;
    localparam int STS_MODE_DONE_BIT = 3;
    localparam int STS_MODE_LSB = 0;
    localparam int STRAP_W = 3;

    // Link error control field layout and reset values
    localparam int LEC_FILT_WAIT_BIT = 5;
    localparam int LEC_CNT_EN_BIT = 4;
    localparam int LEC_THRESH_LSB = 0;
    localparam int THRESH_W = 4;
    localparam logic LEC_FILT_WAIT_RST = 1'b1;
    localparam logic LEC_CNT_EN_RST = 1'b1;
    localparam logic [3:0] LEC_THRESH_RST = 4'h3;

    // Encoder control layout and reset values
    localparam int ENC_CRC_DIS_BIT = 7;
    localparam logic ENC_CRC_DIS_RST = 1'b1;
    localparam logic [6:0] ENC_RSVD_VAL = 7'h03;

    // Frame-valid minimum time reset value
    localparam logic [7:0] FRAME_MIN_RST = 8'h80;

    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int STRAP_SETTLE_NS = 10000;
    localparam int STRAP_SETTLE_CYCLES = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : lmss_pkg

// >>> verilog/strap_decoder.sv
module strap_decoder #(
    parameter int WIDTH = 3,
    parameter int SETTLE_CYCLES = 500
) (
    input wire logic clk_sys_i, // System clock
    input wire logic reset_i, // Asynchronous reset, active high
    input wire logic [WIDTH-1:0] level_i, // Comparator code from strap pin
    output logic [WIDTH-1:0] value_o, // Latched decode
    output logic done_o // Decode finished
);

    typedef enum logic [1:0] {
        DEC_SETTLE = 2'b01,
        DEC_DONE = 2'b10
    } dec_state_t;

    dec_state_t state_q;
    dec_state_t state_d;
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [WIDTH-1:0] prev_q;
    logic [WIDTH-1:0] value_q;
    logic [WIDTH-1:0] value_d;
    logic done_q;
    wire stable = (level_i == prev_q);
    wire settled = (cnt_q >= 16'(SETTLE_CYCLES - 1));

    // Code must hold steady for the whole settle window; a change restarts it
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        value_d = value_q;
        unique case (state_q)
            DEC_SETTLE: begin
                if (!stable) begin
                    cnt_d = 16'h0000;
                end else if (settled) begin
                    value_d = level_i;
                    state_d = DEC_DONE;
                end else begin
                    cnt_d = cnt_q + 16'h0001;
                end
            end
            DEC_DONE: begin
                cnt_d = cnt_q;
            end
        endcase
    end

    // Latched once after reset release, never again
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= DEC_SETTLE;
            cnt_q <= 16'h0000;
            prev_q <= '0;
            value_q <= '0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            prev_q <= level_i;
            value_q <= value_d;
            done_q <= (state_d == DEC_DONE);
        end
    end

    assign value_o = value_q;
    assign done_o = done_q;

endmodule : strap_decoder

// >>> verification/lmss_sva.sv
module lmss_sva (
    input wire logic clk_sys_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic [7:0] reg_addr_i, // Offset
    input wire logic reg_wr_i, // Write strobe
    input wire logic [7:0] reg_wdata_i, // Write data
    input wire logic err_clk0_i, // Fault
    input wire logic err_clk1_i, // Fault
    input wire logic err_parity_i, // Fault
    input wire logic err_dc_balance_i, // Fault
    input wire logic filter_wait_i, // Filter wait
    input wire logic relock_i, // Relock
    input wire logic lock_o, // Locked
    input wire logic lock_lost_o, // Drop pulse
    input wire logic [3:0] error_count_o, // Count
    input wire logic encoder_crc_enable_o, // Crc on
    input wire logic raw_mode_i, // Raw mode
    input wire logic frame_valid_i, // Frame valid
    input wire logic frame_start_o // Start pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ign_q;
    logic en_q;
    logic dis_q;
    logic [3:0] thr_q;
    logic [7:0] fvm_q;
    logic [8:0] fvc_q;
    wire err_any = err_clk0_i | err_clk1_i | err_parity_i | err_dc_balance_i;
    wire [4:0] nxt = {1'b0, error_count_o} + 5'h01;
    // Shadow of the written controls, so expectations never read the design
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            {ign_q, en_q, thr_q} <= 6'h33;
            dis_q <= 1'b1;
            fvm_q <= 8'h80;
            fvc_q <= 9'h000;
        end else begin
            if (reg_wr_i && reg_addr_i == 8'hb9) {ign_q, en_q, thr_q} <= reg_wdata_i[5:0];
            if (reg_wr_i && reg_addr_i == 8'hba) dis_q <= reg_wdata_i[7];
            if (reg_wr_i && reg_addr_i == 8'hbc) fvm_q <= reg_wdata_i;
            fvc_q <= (raw_mode_i && frame_valid_i) ? fvc_q + 9'h001 : 9'h000;
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);
    // A fault that the lock detector must see
    sequence s_err;
        lock_o && err_any && !(ign_q && filter_wait_i);
    endsequence
    AST_CNT_UP: assert property (s_err ##0 (en_q && nxt < {1'b0, thr_q})
        |=> lock_o && error_count_o == $past(error_count_o) + 4'h1)
        else $error("error count did not step");
    AST_THRESH: assert property (s_err ##0 (en_q && nxt >= {1'b0, thr_q})
        |=> lock_lost_o && !lock_o)
        else $error("lock kept at threshold");
    AST_DIS_DROP: assert property (s_err ##0 !en_q |=> lock_lost_o && !lock_o)
        else $error("lock kept with counting off");
    AST_IGNORE: assert property (lock_o && ign_q && filter_wait_i
        |=> lock_o && $stable(error_count_o))
        else $error("error counted during filter wait");
    AST_LOST_CLR: assert property (lock_lost_o |-> error_count_o == 4'h0 ##1 !lock_lost_o)
        else $error("count not cleared on drop");
    AST_RELOCK: assert property (!lock_o && relock_i |=> lock_o && error_count_o == 4'h0)
        else $error("relock did not start from zero");
    AST_CRC: assert property (encoder_crc_enable_o == !dis_q)
        else $error("crc enable wrong");
    AST_FS_FIRE: assert property (raw_mode_i && frame_valid_i && fvc_q == {1'b0, fvm_q}
        |=> frame_start_o)
        else $error("frame start missing");
    AST_FS_ONLY: assert property (frame_start_o |-> fvc_q == {1'b0, fvm_q} + 9'h001)
        else $error("frame start too early");
endmodule : lmss_sva

bind link_monitor_strap_status lmss_sva u_sva (.clk_sys_i, .reset_i, .reg_addr_i, .reg_wr_i,
    .reg_wdata_i, .err_clk0_i, .err_clk1_i, .err_parity_i, .err_dc_balance_i, .filter_wait_i,
    .relock_i, .lock_o, .lock_lost_o, .error_count_o, .encoder_crc_enable_o, .raw_mode_i,
    .frame_valid_i, .frame_start_o);

// >>> verification/ser_model.sv
module ser_model (
    input wire logic clk_sys_i, // Clock
    output logic [3:0] fault_o, // Dc balance, parity, clock bit 1, clock bit 0
    output logic filter_wait_o, // Equalizer wait
    output logic frame_valid_o // Frame valid
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        fault_o = 4'h0;
        filter_wait_o = 1'b0;
        frame_valid_o = 1'b0;
    end
    // One spoilt frame; each mask bit breaks one monitored field
    task automatic send_err(input logic [3:0] m, input logic fw);
        @(negedge clk_sys_i);
        fault_o = m;
        filter_wait_o = fw;
        @(negedge clk_sys_i);
        fault_o = 4'h0;
        filter_wait_o = 1'b0;
    endtask : send_err
    // Frame valid held for n link clock periods
    task automatic frame(input int n);
        @(negedge clk_sys_i);
        frame_valid_o = 1'b1;
        repeat (n) @(negedge clk_sys_i);
        frame_valid_o = 1'b0;
    endtask : frame
endmodule : ser_model

// >>> verification/link_monitor_strap_status_bench.sv
module link_monitor_strap_status_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [2:0] index_strap_level_i = 3'h0;
    logic [2:0] mode_strap_level_i = 3'h0;
    logic relock_i = 1'b0;
    logic raw_mode_i = 1'b1;
    logic [7:0] seed = 8'h42;
    logic [3:0] flt;
    logic filter_wait_i;
    logic frame_valid_i;
    wire logic [7:0] reg_rdata_o;
    wire logic reg_rvalid_o, lock_o, lock_lost_o, encoder_crc_enable_o, frame_start_o;
    wire logic [3:0] error_count_o;
    logic [7:0] rd_q [$];
    logic [7:0] adr [8] = '{8'hb6, 8'hb7, 8'hb9, 8'hba, 8'hbb, 8'hbc, 8'hbd, 8'h40};
    logic [7:0] rst [8] = '{8'h18, 8'h00, 8'h33, 8'h83, 8'h74, 8'h80, 8'h00, 8'h00};
    int flen [4] = '{2, 3, 9, 9};
    int n_errors = 0;
    int check_count = 0;
    int n_lost = 0;
    int n_fs = 0;
    int base;
    always #10 clk_sys_i = ~clk_sys_i;
    ser_model u_ser (.clk_sys_i, .fault_o(flt), .filter_wait_o(filter_wait_i),
        .frame_valid_o(frame_valid_i));
    link_monitor_strap_status #(.STRAP_SETTLE(4)) u_dut (.clk_sys_i, .reset_i, .reg_addr_i,
        .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .index_strap_level_i,
        .mode_strap_level_i, .err_clk0_i(flt[0]), .err_clk1_i(flt[1]), .err_parity_i(flt[2]),
        .err_dc_balance_i(flt[3]), .filter_wait_i, .relock_i, .lock_o, .lock_lost_o,
        .error_count_o, .encoder_crc_enable_o, .raw_mode_i, .frame_valid_i, .frame_start_o);
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr_next
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask : idle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_sys_i);
        reg_wr_i = 1'b1;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        reg_wr_i = 1'b0;
    endtask : wr
    // The expected value is noted before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk_sys_i);
        rd_q.push_back(exp);
        reg_rd_i = 1'b1;
        reg_addr_i = a;
        @(negedge clk_sys_i);
        reg_rd_i = 1'b0;
    endtask : rd
    task automatic relock();
        @(negedge clk_sys_i);
        relock_i = 1'b1;
        @(negedge clk_sys_i);
        relock_i = 1'b0;
    endtask : relock
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : test_done
    // Watcher: pulses are counted, read data taken against the oldest note
    always @(negedge clk_sys_i) begin
        n_lost += (lock_lost_o === 1'b1);
        n_fs += (frame_start_o === 1'b1);
        if (reg_rvalid_o === 1'b1) begin
            chk("rdata", (rd_q.size() > 0) ? rd_q.pop_front() : 8'hxx, reg_rdata_o);
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_errors++;
        $display("[ERR] run expected end seen timeout");
        test_done();
    end
    initial begin
        seed = lfsr_next(seed);
        {mode_strap_level_i, index_strap_level_i} = seed[5:0];
        repeat (16) @(posedge clk_sys_i);
        @(negedge clk_sys_i);
        reset_i = 1'b0;
        idle(12);
        for (int i = 0; i < 2; i++) begin
            rd(8'hb8, {1'b1, index_strap_level_i, 1'b1, mode_strap_level_i});
            wr(8'hb8, 8'h00);
        end
        for (int i = 0; i < 8; i++) rd(adr[i], rst[i]);
        $display("test reset values done");
        foreach (flen[i]) begin
            base = n_lost;
            wr(8'hb9, 8'h30 | 8'(flen[i] - 2));
            relock();
            for (int k = 0; k < flen[i] - 3; k++) begin
                seed = lfsr_next(seed);
                u_ser.send_err(seed[3:0] | 4'h1, 1'b0);
            end
            idle(2);
            chk("count", 8'((flen[i] > 3) ? flen[i] - 3 : 0), {4'h0, error_count_o});
            u_ser.send_err(4'h8, 1'b0);
            idle(2);
            chk("drops", 8'(base + 1), 8'(n_lost));
            chk("lock", 8'h00, {7'h00, lock_o});
        end
        wr(8'hb9, 8'h3f);
        relock();
        for (int k = 0; k < 4; k++) u_ser.send_err(4'h1 << k, 1'b1);
        chk("ignored", 8'h00, {4'h0, error_count_o});
        wr(8'hb9, 8'h1f);
        for (int k = 0; k < 4; k++) u_ser.send_err(4'h1 << k, 1'b1);
        chk("counted", 8'h04, {4'h0, error_count_o});
        base = n_lost;
        wr(8'hb9, 8'h0f);
        u_ser.send_err(4'h2, 1'b0);
        idle(2);
        chk("first drop", 8'(base + 1), 8'(n_lost));
        $display("test link errors done");
        wr(8'hba, 8'h00);
        wr(8'h4a, 8'h10);
        rd(8'h4a, 8'h00);
        rd(8'hba, 8'h03);
        chk("crc on", 8'h01, {7'h00, encoder_crc_enable_o});
        wr(8'hbc, 8'h02);
        for (int i = 0; i < 4; i++) begin
            raw_mode_i = (i != 3);
            u_ser.frame(flen[i]);
            idle(3);
            chk("frame starts", (i > 1) ? 8'h02 : 8'(i), 8'(n_fs));
        end
        reset_i = 1'b1;
        idle(2);
        reset_i = 1'b0;
        idle(12);
        rd(8'hb9, 8'h33);
        idle(3);
        chk("pending reads", 8'h00, 8'(rd_q.size()));
        $display("test crc frame reset done");
        test_done();
    end
endmodule : link_monitor_strap_status_bench
